//--- design/sra_core.sv
// SPI register access command layer: 32-bit command frames, answers in the next frame.
// Assumes SPI mode 0 on spi_sclk; register file lives in clk domain, 8-bit registers.
`timescale 1ns/1ps
module sra_core
    import sra_pkg::*;
#(
    parameter int          NUM_REGS  = 64,       // Implemented register count
    parameter logic [63:0] RO_MASK   = 64'h0     // Set bit marks a read-only register
) (
    input  wire logic        clk,               // System clock
    input  wire logic        rst,               // Asynchronous reset, active high
    input  wire logic        spi_sclk,          // Link clock from the host
    input  wire logic        spi_cs_n,          // Frame select, active low
    input  wire logic        spi_mosi,          // Serial data from host
    output logic             spi_miso,          // Serial data to host
    output logic             spi_miso_oe,       // High while driving spi_miso
    input  wire logic        miso_verify_error, // Output verification fault, level
    input  wire logic [1:0]  fine_health,       // Detailed status for error answers
    input  wire logic [1:0]  coarse_health_in,  // Basic status for normal answers
    input  wire logic [7:0]  ro_value [NUM_REGS], // Values shown by read-only registers
    output logic      [7:0]  reg_value [NUM_REGS], // Register contents
    output logic             init_done_lock,    // Lock bit of the lock register
    output logic             write_strobe       // Pulse on each committed write
);
    // Refuse sizes that the word decode or the lock register cannot serve
    if (NUM_REGS < 2 || NUM_REGS > 64 || NUM_REGS % 2 != 0) begin : g_bad_count
        $error("NUM_REGS must be even and within 2..64");
    end
    if (NUM_REGS <= int'(LOCK_REG_ADDR)) begin : g_bad_lock
        $error("NUM_REGS must cover the lock register");
    end

    localparam int AW = $clog2(NUM_REGS);

    // ---------------- Link domain ----------------
    localparam logic [5:0] CNT_FULL = 6'(FRAME_BITS);

    logic [31:0] rx_shift_q;
    logic [5:0]  bit_cnt_q;
    logic        seen_tog_q;
    logic        frame_tog_q;
    logic        frame_ok;
    logic [31:0] rx_frame_q;
    logic [31:0] tx_shift_q;
    logic        first_q;
    logic [31:0] answer_q;

    // Command bits, sampled on the rising link edge
    always_ff @(posedge spi_sclk or posedge rst) begin
        if (rst) begin
            rx_shift_q <= 32'h0;
        end else if (!spi_cs_n) begin
            rx_shift_q <= {rx_shift_q[30:0], spi_mosi};
        end
    end

    // Edge count of the open frame. frame_tog_q stands still inside a frame, so a
    // mismatch marks the first edge after the last close: a cut frame leaves no offset.
    always_ff @(posedge spi_sclk or posedge rst) begin
        if (rst) begin
            bit_cnt_q  <= 6'h00;
            seen_tog_q <= 1'b0;
        end else if (!spi_cs_n) begin
            seen_tog_q <= frame_tog_q;
            if (seen_tog_q != frame_tog_q) begin
                bit_cnt_q <= 6'h01;
            end else if (bit_cnt_q != CNT_FULL + 6'h01) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    // Exactly 32 edges inside this frame; a frame without edges fails the toggle match
    assign frame_ok = (bit_cnt_q == CNT_FULL) && (seen_tog_q == frame_tog_q);

    // The select rising edge closes the frame; the link clock may stop afterwards
    always_ff @(posedge spi_cs_n or posedge rst) begin
        if (rst) begin
            frame_tog_q <= 1'b0;
            rx_frame_q  <= 32'h0;
        end else begin
            frame_tog_q <= ~frame_tog_q;
            rx_frame_q  <= frame_ok ? rx_shift_q : 32'h0;
        end
    end

    // answer_q settles a few clk cycles after a close and then stands until the next
    // close, so the link side reads it directly. Limitation: the select must stay high
    // between frames for longer than the decode takes.
    always_ff @(negedge spi_sclk or posedge rst or posedge spi_cs_n) begin
        if (rst) begin
            tx_shift_q <= 32'h0;
            first_q    <= 1'b1;
        end else if (spi_cs_n) begin
            tx_shift_q <= 32'h0;
            first_q    <= 1'b1;
        end else begin
            first_q    <= 1'b0;
            tx_shift_q <= first_q ? {answer_q[30:0], 1'b0} : {tx_shift_q[30:0], 1'b0};
        end
    end

    // First bit comes straight from the held answer before any shift edge
    logic miso_bit;
    assign miso_bit    = first_q ? answer_q[31] : tx_shift_q[31];
    assign spi_miso    = spi_cs_n ? 1'b0 : miso_bit;
    assign spi_miso_oe = ~spi_cs_n;

    // ---------------- System domain ----------------
    logic [2:0]  tog_sync_q;
    logic        frame_done;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_sync_q <= 3'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], frame_tog_q};
        end
    end
    assign frame_done = tog_sync_q[2] ^ tog_sync_q[1];

    logic [1:0] verr_sync_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            verr_sync_q <= 2'h0;
        end else begin
            verr_sync_q <= {verr_sync_q[0], miso_verify_error};
        end
    end

    // Frame decode; rx_frame_q is stable for many clk cycles after the toggle
    logic [7:0] crc_calc;
    sra_crc8 u_crc (
        .payload (rx_frame_q[31:8]),
        .crc     (crc_calc)
    );

    logic [3:0] op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       spi_err;
    logic       is_read;
    logic       is_write;
    logic       addr_ok;
    logic       lock_ok;
    logic       write_ok;
    assign op       = rx_frame_q[OP_MSB:OP_LSB];
    assign addr     = rx_frame_q[ADDR_MSB:ADDR_LSB];
    assign wdata    = rx_frame_q[DATA_MSB:DATA_LSB];
    // Only the two register requests are served; every other code answers an error
    always_comb begin
        is_read  = 1'b0;
        is_write = 1'b0;
        case (op)
            OP_READ: begin
                is_read = 1'b1;
            end
            OP_WRITE: begin
                is_write = 1'b1;
            end
            default: begin
                is_read  = 1'b0;
                is_write = 1'b0;
            end
        endcase
    end
    assign spi_err  = (crc_calc != rx_frame_q[CRC_MSB:CRC_LSB])
                    || (rx_frame_q[ZERO_MSB:ZERO_LSB] != 4'h0)
                    || (is_read && rx_frame_q[DATA_MSB:DATA_LSB] != 8'h0);
    assign addr_ok  = (32'(addr) < NUM_REGS);
    assign lock_ok  = !init_done_lock || (addr == LOCK_REG_ADDR);
    assign write_ok = is_write && !spi_err && !verr_sync_q[1] && lock_ok && addr_ok;

    // Register file; commit only after the frame has closed
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;
    logic [AW-1:0] word_base;
    assign word_base = {addr[AW-1:1], 1'b0};
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    regs_q[g] <= REG_RESET_VALUE;
                end else if (frame_done && write_ok && addr_ok && addr[AW-1:0] == AW'(g)
                             && !RO_MASK[g]) begin
                    if (init_done_lock && addr == LOCK_REG_ADDR) begin
                        regs_q[g] <= (regs_q[g] & ~LOCK_RESET_MASK)
                                   | (wdata & LOCK_RESET_MASK);
                    end else begin
                        regs_q[g] <= wdata;
                    end
                end
            end
            assign reg_value[g] = RO_MASK[g] ? ro_value[g] : regs_q[g];
        end
    endgenerate

    assign init_done_lock = regs_q[LOCK_REG_ADDR[AW-1:0]][7];
    assign rd_lo = addr_ok ? reg_value[word_base] : 8'h00;
    assign rd_hi = addr_ok ? reg_value[word_base + AW'(1)] : 8'h00;

    // Answer build: read data reflects contents at the closing edge
    logic [23:0] ans_payload;
    logic [7:0]  ans_crc;
    logic        ans_err;
    always_comb begin
        ans_err = spi_err || verr_sync_q[1] || (is_write && !write_ok)
                || !(is_read || is_write) || !addr_ok;
        if (ans_err) begin
            // The error answer carries the command field rotated right by one bit, the response code of the failed request
            ans_payload = {op[0], op[3:1], HEALTH_ERROR, 16'h0000, fine_health};
        end else if (is_read) begin
            ans_payload = {RSP_READ, coarse_health_in, 2'b00, rd_hi, rd_lo};
        end else begin
            ans_payload = {RSP_WRITE, coarse_health_in, 2'b00, rd_hi, rd_lo};
        end
    end

    sra_crc8 u_ans_crc (
        .payload (ans_payload),
        .crc     (ans_crc)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            answer_q     <= {RSP_ERROR, HEALTH_ERROR, 26'h0};
            write_strobe <= 1'b0;
        end else begin
            write_strobe <= frame_done && write_ok && !RO_MASK[addr[AW-1:0]];
            if (frame_done) begin
                answer_q <= {ans_payload, ans_crc};
            end
        end
    end
endmodule : sra_core

//--- design/sra_pkg.sv
// Constants for the SPI register access command layer.
// Assumes a 32-bit frame, MSB first, SPI mode 0 framed by an active-low select.
package sra_pkg;
    localparam int          FRAME_BITS      = 32;
    localparam logic [3:0]  OP_READ         = 4'hC;
    localparam logic [3:0]  OP_WRITE        = 4'h8;
    localparam logic [3:0]  RSP_READ        = 4'h6;
    localparam logic [3:0]  RSP_WRITE       = 4'h4;
    localparam logic [3:0]  RSP_ERROR       = 4'h0;
    localparam logic [1:0]  HEALTH_ERROR    = 2'h3;
    localparam logic [1:0]  HEALTH_NORMAL   = 2'h1;
    localparam int          OP_MSB          = 31;
    localparam int          OP_LSB          = 28;
    localparam int          ZERO_MSB        = 27;
    localparam int          ZERO_LSB        = 24;
    localparam int          ADDR_MSB        = 23;
    localparam int          ADDR_LSB        = 16;
    localparam int          DATA_MSB        = 15;
    localparam int          DATA_LSB        = 8;
    localparam int          CRC_MSB         = 7;
    localparam int          CRC_LSB         = 0;
    localparam logic [7:0]  CRC_POLY        = 8'h2F;
    localparam logic [7:0]  CRC_SEED        = 8'hFF;
    localparam logic [7:0]  LOCK_REG_ADDR   = 8'h14;
    localparam logic [7:0]  LOCK_RESET_MASK = 8'h03;
    localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
endpackage : sra_pkg

//--- design/sra_crc8.sv
// Combinational 8-bit CRC over a 24-bit payload, MSB first.
// Assumes the polynomial and seed constants of the package.
`timescale 1ns/1ps
module sra_crc8
    import sra_pkg::*;
(
    input  wire logic [23:0] payload,  // Bits 31:8 of a frame
    output logic      [7:0]  crc       // Resulting check byte
);
    always_comb begin
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ payload[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule : sra_crc8

//--- testbench/sra_core_checker.sv
// Port-level checker for the SPI register command block.
// Assumes it is bound to sra_core and sees only that module's ports.
`timescale 1ns/1ps
module sra_core_checker
    import sra_pkg::*;
#(
    parameter int          NUM_REGS = 64,    // Implemented register count
    parameter logic [63:0] RO_MASK  = 64'h0  // Read-only register mask
) (
    input wire logic       clk,                  // System clock
    input wire logic       rst,                  // Asynchronous reset
    input wire logic       spi_cs_n,             // Frame select
    input wire logic       spi_miso,             // Device data
    input wire logic       spi_miso_oe,          // Device drive enable
    input wire logic [7:0] reg_value [NUM_REGS], // Register contents
    input wire logic       init_done_lock,       // Lock bit
    input wire logic       write_strobe          // Committed write pulse
);
    logic [8*NUM_REGS-1:0] regs_flat;
    logic [8*NUM_REGS-1:0] regs_guard;

    // Reset bits of the lock register are masked: they stay writable under lock
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_flat[8*i +: 8] = reg_value[i];
        end
        regs_guard = regs_flat;
        regs_guard[8*int'(LOCK_REG_ADDR) +: 2] = 2'h0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    oe_follows_a: assert property (spi_miso_oe == !spi_cs_n)
        else $error("miso enable does not follow select");
    miso_idle_a: assert property ($past(spi_cs_n) && spi_cs_n |-> !spi_miso)
        else $error("miso not low while deselected");
    strobe_pulse_a: assert property (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    strobe_after_frame_a: assert property (write_strobe |-> $past(spi_cs_n) && $past(spi_cs_n, 2))
        else $error("write committed inside a frame");
    change_needs_strobe_a: assert property ($changed(regs_flat) |-> (write_strobe || $past(write_strobe)) or (##1 write_strobe))
        else $error("register changed without a committed write");
    lock_spares_a: assert property ($past(init_done_lock) && init_done_lock |-> $stable(regs_guard))
        else $error("locked register changed");
    lock_bit_tie_a: assert property (init_done_lock == reg_value[LOCK_REG_ADDR][7])
        else $error("lock output differs from lock register");
    reset_clear_a: assert property ($fell(rst) |-> !init_done_lock && reg_value[LOCK_REG_ADDR] == REG_RESET_VALUE)
        else $error("lock register not cleared by reset");

    strobe_c: cover property (write_strobe);
    lock_c: cover property ($rose(init_done_lock));
    frame_c: cover property ($fell(spi_cs_n));
endmodule : sra_core_checker

bind sra_core sra_core_checker #(.NUM_REGS(NUM_REGS), .RO_MASK(RO_MASK)) u_chk (.clk(clk), .rst(rst),
    .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .reg_value(reg_value),
    .init_done_lock(init_done_lock), .write_strobe(write_strobe));

//--- testbench/sra_host_model.sv
// Host model: sends 32-bit command frames in SPI mode 0, collects the answer.
// Assumes a 160 ns link clock that stands still between frames.
`timescale 1ns/1ps
module sra_host_model
    import sra_pkg::*;
(
    output logic      spi_sclk, // Link clock, idle low
    output logic      spi_cs_n, // Frame select
    output logic      spi_mosi, // Command bits, MSB first
    input  wire logic spi_miso  // Answer bits
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    function automatic logic [7:0] crc8(input logic [23:0] p);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ p[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8

    // The bad flag corrupts the check byte on purpose
    task automatic xfer(input logic [23:0] pl, input logic bad, output logic [31:0] rsp);
        logic [31:0] f;
        f = {pl, crc8(pl) ^ {7'h0, bad}};
        spi_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spi_mosi = f[i];
            #80 spi_sclk = 1'b1;
            rsp[i] = spi_miso;
            #80 spi_sclk = 1'b0;
        end
        #80 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // Released line must not show a stale bit
    endtask : xfer

    // Frame cut short after a few edges; the device must drop it
    task automatic cut(input int edges);
        spi_cs_n = 1'b0;
        for (int i = 0; i < edges; i++) begin
            spi_mosi = 1'b1;
            #80 spi_sclk = 1'b1;
            #80 spi_sclk = 1'b0;
        end
        #80 spi_cs_n = 1'b1;
    endtask : cut
endmodule : sra_host_model

//--- testbench/tb.sv
// Testbench: register commands through the host model, answers checked a frame later.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/1ps
module tb import sra_pkg::*;;
    localparam logic [1:0]  FH  = 2'h2;
    localparam logic [1:0]  CH  = 2'h1;
    // Error answers carry the response code of the failed request (its command field rotated right by one bit)
    localparam logic [23:0] ERR_NONE = {RSP_ERROR, HEALTH_ERROR, 16'h0, FH};
    localparam logic [23:0] ERR_RD   = {RSP_READ, HEALTH_ERROR, 16'h0, FH};
    localparam logic [23:0] ERR_WR   = {RSP_WRITE, HEALTH_ERROR, 16'h0, FH};
    localparam logic [23:0] WH  = {RSP_WRITE, CH, 2'b00, 16'h0};
    logic       clk, rst, miso_verify_error;
    logic       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, init_done_lock, write_strobe;
    logic [7:0] ro_value [64];
    logic [7:0] reg_value [64];
    int         n_errors = 0;
    int         compares = 0;

    sra_core #(.NUM_REGS(64), .RO_MASK(64'h40)) u_dut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .miso_verify_error(miso_verify_error), .fine_health(FH), .coarse_health_in(CH),
        .ro_value(ro_value), .reg_value(reg_value), .init_done_lock(init_done_lock),
        .write_strobe(write_strobe));
    sra_host_model u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    function automatic logic [23:0] rd(input logic [7:0] a);
        return {OP_READ, 4'h0, a, 8'h00};
    endfunction : rd
    function automatic logic [23:0] wr(input logic [7:0] a, input logic [7:0] d);
        return {OP_WRITE, 4'h0, a, d};
    endfunction : wr
    function automatic logic [23:0] rr(input logic [7:0] hi, input logic [7:0] lo);
        return {RSP_READ, CH, 2'b00, hi, lo};
    endfunction : rr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Mode 1 checks the whole answer, mode 2 only its header byte (write data is implementation timing)
    task automatic step(input logic [23:0] c, input logic bad, input logic ve, input logic [1:0] m, input logic [23:0] e);
        logic [31:0] r;
        @(posedge clk);
        #1 miso_verify_error = ve;
        u_host.xfer(c, bad, r);
        repeat (10) @(posedge clk);
        if (m == 2'd1) check(r, {e, u_host.crc8(e)});
        if (m == 2'd2) check({r[31:24], 24'h0}, {e[23:16], 24'h0});
    endtask : step

    task final_report;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #300000;
        n_errors++;
        final_report;
    end

    initial begin
        rst = 1'b1;
        miso_verify_error = 1'b0;
        foreach (ro_value[i]) ro_value[i] = 8'h5A;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge clk);
        step(wr(8'h05, 8'hA5), 1'b0, 1'b0, 2'd0, ERR_NONE);
        step(wr(8'h04, 8'h3C), 1'b0, 1'b0, 2'd2, WH);
        step(wr(8'h06, 8'h77), 1'b0, 1'b0, 2'd2, WH);
        step(rd(8'h04), 1'b0, 1'b0, 2'd2, WH);
        step(rd(8'h05), 1'b0, 1'b0, 2'd1, rr(8'hA5, 8'h3C));
        step(rd(8'h04), 1'b1, 1'b0, 2'd1, rr(8'hA5, 8'h3C));
        step(wr(8'h05, 8'hFF) | 24'h010000, 1'b0, 1'b0, 2'd1, ERR_RD);
        step(rd(8'h04), 1'b0, 1'b0, 2'd1, ERR_WR);
        step(wr(8'h14, 8'h80), 1'b0, 1'b0, 2'd1, rr(8'hA5, 8'h3C));
        step(wr(8'h04, 8'h11), 1'b0, 1'b0, 2'd2, WH);
        step(wr(8'h14, 8'h02), 1'b0, 1'b0, 2'd1, ERR_WR);
        step(rd(8'h14), 1'b0, 1'b0, 2'd2, WH);
        step(rd(8'h04), 1'b0, 1'b1, 2'd1, rr(8'h00, 8'h82));
        step(rd(8'h80), 1'b0, 1'b0, 2'd1, ERR_RD);
        step(rd(8'h04), 1'b0, 1'b0, 2'd1, ERR_RD);
        step(rd(8'h04), 1'b0, 1'b0, 2'd1, rr(8'hA5, 8'h3C));
        @(posedge clk);
        #1 u_host.cut(8);
        repeat (10) @(posedge clk);
        step(rd(8'h04), 1'b0, 1'b0, 2'd1, ERR_NONE);
        check({24'h0, reg_value[6]}, {24'h0, 8'h5A});
        check({24'h0, reg_value[4]}, {24'h0, 8'h3C});
        check({24'h0, reg_value[20]}, {24'h0, 8'h82});
        check({31'h0, init_done_lock}, 32'h1);
        final_report;
    end
endmodule : tb
